// ### rtl/ivm_vector_map.sv
// What this block does
// - Vector address is base plus 3FC minus 4n
// - NMI is number 15, fixed level 15
// - External inputs 0-7 map to numbers 16-23
// - Numbers 0 to 14 carry no level
// - DMA channels 0-4 map to numbers 33-37
// - Reload timer 3 and oscillator wait share 46
// - Delayed interrupt bit raises number 63
// - Numbers 64 and 65 stay unassigned
// - Numbers 80-255 only by software instruction
// - Pick lowest level, then lowest number; report
// - Wake from stop on NMI or enabled level
module ivm_vector_map #(
  parameter int N_PERIPH = 48
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic nmi_req,
  input ivm_pkg::ivm_src_type src_req,
  input ivm_pkg::ivm_levels_type level_reg,
  input wire logic [31:0] table_base_reg,
  input wire logic vec_req,
  input wire logic [7:0] vec_num,
  output logic irq_valid,
  output logic [4:0] irq_level,
  output logic [7:0] irq_number,
  output logic wake_req,
  output ivm_pkg::ivm_vec_type vec_out
);

  import ivm_pkg::*;

  // Elaboration check: the table has exactly one slot per peripheral
  if (N_PERIPH != NUM_PERIPH)
  begin : g_bad_param
    $error("ivm_vector_map: N_PERIPH must equal the table size");
  end

  // Elaboration check: the tree must hold every number up to 63
  if (TREE_LEAVES < int'(PERIPH_LAST) + 1)
  begin : g_bad_tree
    $error("ivm_vector_map: arbitration tree too small");
  end

  typedef struct packed {
    logic irq_valid;
    logic [4:0] irq_level;
    logic [7:0] irq_number;
    logic wake;
    ivm_fetch_type fetch;
    logic [7:0] num;
    logic [31:0] base;
    ivm_vec_type vec;
  } ivm_state_type;

  ivm_state_type state_ff;
  ivm_state_type nxt_state;

  logic [NUM_PERIPH-1:0] periph_req;
  logic any_enabled;
  ivm_cand_type cand [0:2*TREE_LEAVES-2];

  // Fold the named sources into the peripheral request vector
  always_comb
  begin
    periph_req = src_req.misc;
    periph_req[EXT_POS +: EXT_CNT] =
      periph_req[EXT_POS +: EXT_CNT] | src_req.ext;
    periph_req[DMA_POS +: DMA_CNT] =
      periph_req[DMA_POS +: DMA_CNT] | src_req.dma;
    periph_req[SHARED_POS] =
      periph_req[SHARED_POS] | src_req.rt3 | src_req.osc_wait;
    periph_req[DELAY_POS] = periph_req[DELAY_POS] | src_req.delay_bit;
  end

  // Tree leaves: one per interrupt number 0 to 63
  for (genvar n = 0; n < TREE_LEAVES; n++)
  begin : g_leaf
    localparam logic [7:0] LEAF_NUM = 8'(n);
    if (n == int'(NMI_NUM))
    begin : g_nmi
      assign cand[TREE_LEAVES-1+n] = '{nmi_req, NMI_LEVEL, LEAF_NUM};
    end
    else if (n >= int'(PERIPH_FIRST))
    begin : g_periph
      // level from register n minus 16
      assign cand[TREE_LEAVES-1+n] =
        '{periph_req[n-int'(PERIPH_FIRST)] &&
          (level_reg[n-int'(PERIPH_FIRST)] != LEVEL_OFF),
          level_reg[n-int'(PERIPH_FIRST)], LEAF_NUM};
    end
    else
    begin : g_trap
      assign cand[TREE_LEAVES-1+n] = '{1'b0, LEVEL_OFF, LEAF_NUM};
    end
  end

  for (genvar i = 0; i < TREE_LEAVES - 1; i++)
  begin : g_node
    ivm_pick u_pick (
      .cand_a(cand[2*i+1]),
      .cand_b(cand[2*i+2]),
      .winner(cand[i])
    );
  end

  // any peripheral request not at the disabled level
  always_comb
  begin
    any_enabled = 1'b0;
    for (int k = 0; k < NUM_PERIPH; k++)
    begin
      if (periph_req[k] && (level_reg[k] != LEVEL_OFF))
      begin
        any_enabled = 1'b1;
      end
    end
  end

  // Next state: arbitration result and vector fetch sequence
  always_comb
  begin
    logic [7:0] idx;
    idx = 8'h00;
    nxt_state = state_ff;
    // Winner is registered and shows one edge later
    nxt_state.irq_valid = cand[0].valid;
    nxt_state.irq_level = cand[0].valid ? cand[0].level : LEVEL_OFF;
    nxt_state.irq_number = cand[0].valid ? cand[0].number : 8'h00;
    nxt_state.wake = nmi_req | any_enabled;
    // Answer strobe is high for one cycle only
    nxt_state.vec.ack = 1'b0;
    case (state_ff.fetch)
      ST_IDLE:
      begin
        // Number and base are sampled at the taking edge
        if (vec_req)
        begin
          nxt_state.num = vec_num;
          nxt_state.base = table_base_reg;
          nxt_state.fetch = ST_CALC;
        end
      end
      ST_CALC:
      begin
        // base plus offset falling 4 per number
        nxt_state.vec.addr = state_ff.base + VEC_OFS_TOP -
                             {22'h000000, state_ff.num, 2'b00};
        idx = state_ff.num - PERIPH_FIRST;
        if (state_ff.num == NMI_NUM)
        begin
          nxt_state.vec.has_level = 1'b1;
          nxt_state.vec.level = NMI_LEVEL;
        end
        else if ((state_ff.num >= PERIPH_FIRST) &&
                 (state_ff.num <= PERIPH_LAST))
        begin
          nxt_state.vec.has_level = 1'b1;
          nxt_state.vec.level = level_reg[idx[5:0]];
        end
        else
        begin
          // traps below 15 and numbers above 63 have no level
          nxt_state.vec.has_level = 1'b0;
          nxt_state.vec.level = LEVEL_OFF;
        end
        nxt_state.fetch = ST_DONE;
      end
      ST_DONE:
      begin
        nxt_state.vec.ack = 1'b1;
        nxt_state.fetch = ST_IDLE;
      end
      default:
      begin
        nxt_state.fetch = ST_IDLE;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      // Base falls back to the default table location
      state_ff <= '{
        irq_valid: 1'b0,
        irq_level: LEVEL_OFF,
        irq_number: 8'h00,
        wake: 1'b0,
        fetch: ST_IDLE,
        num: 8'h00,
        base: BASE_DEFAULT,
        vec: '{1'b0, 32'h0000_0000, 1'b0, LEVEL_OFF}
      };
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Registered outputs
  assign irq_valid = state_ff.irq_valid;
  assign irq_level = state_ff.irq_level;
  assign irq_number = state_ff.irq_number;
  assign wake_req = state_ff.wake;
  // Address and level hold until the next lookup
  assign vec_out = state_ff.vec;

endmodule : ivm_vector_map

// ### include/ivm_pkg.sv
package ivm_pkg;

  // Vector table geometry
  localparam logic [31:0] VEC_OFS_TOP = 32'h0000_03fc;
  localparam logic [31:0] BASE_DEFAULT = 32'h000f_fc00;

  // Fixed interrupt numbers
  localparam logic [7:0] NMI_NUM = 8'h0f;
  localparam logic [7:0] PERIPH_FIRST = 8'h10;
  localparam logic [7:0] PERIPH_LAST = 8'h3f;
  localparam logic [7:0] KERNEL_NUM_A = 8'h40;
  localparam logic [7:0] KERNEL_NUM_B = 8'h41;
  localparam logic [7:0] SWI_FIRST = 8'h50;

  // Positions inside the peripheral request vector (number minus 16)
  localparam int EXT_POS = 0;
  localparam int EXT_CNT = 8;
  localparam int DMA_POS = 17;
  localparam int DMA_CNT = 5;
  localparam int SHARED_POS = 30;
  localparam int DELAY_POS = 47;
  localparam int NUM_PERIPH = 48;
  localparam int TREE_LEAVES = 64;

  // Levels
  localparam logic [4:0] NMI_LEVEL = 5'h0f;
  localparam logic [4:0] LEVEL_OFF = 5'h1f;

  typedef logic [NUM_PERIPH-1:0][4:0] ivm_levels_type;

  // Request sources from the peripherals
  typedef struct packed {
    logic [EXT_CNT-1:0] ext;
    logic [DMA_CNT-1:0] dma;
    logic rt3;
    logic osc_wait;
    logic delay_bit;
    logic [NUM_PERIPH-1:0] misc;
  } ivm_src_type;

  // One arbitration candidate
  typedef struct packed {
    logic valid;
    logic [4:0] level;
    logic [7:0] number;
  } ivm_cand_type;

  // Vector fetch answer
  typedef struct packed {
    logic ack;
    logic [31:0] addr;
    logic has_level;
    logic [4:0] level;
  } ivm_vec_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALC = 2'b01,
    ST_DONE = 2'b11
  } ivm_fetch_type;

endpackage : ivm_pkg

// ### rtl/ivm_pick.sv
// Picks the stronger of two candidates: lower level, then lower number
module ivm_pick
  import ivm_pkg::*;
(
  input ivm_pkg::ivm_cand_type cand_a,
  ivm_pkg::ivm_cand_type cand_b,
  output ivm_pkg::ivm_cand_type winner
);

  logic a_wins;

  // Level first, interrupt number breaks ties
  assign a_wins = cand_a.valid &&
                  (!cand_b.valid ||
                   (cand_a.level < cand_b.level) ||
                   ((cand_a.level == cand_b.level) &&
                    (cand_a.number <= cand_b.number)));

  assign winner = a_wins ? cand_a : cand_b;

endmodule : ivm_pick

// ### dv/ivm_vector_map_assertions.sv
module ivm_vector_map_assertions
  import ivm_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic nmi_req,
  input ivm_pkg::ivm_src_type src_req,
  input wire logic [31:0] table_base_reg,
  input wire logic vec_req,
  input wire logic [7:0] vec_num,
  input wire logic irq_valid,
  input wire logic [7:0] irq_number,
  input wire logic wake_req,
  input ivm_pkg::ivm_vec_type vec_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Lookup taken, answer three edges on
  sequence take_s;
    $rose(vec_req) ##3 1'b1;
  endsequence
  a_vec_addr: assert property (vec_out.ack |-> vec_out.addr ==
    $past(table_base_reg, 3) + VEC_OFS_TOP - {$past(vec_num, 3), 2'b00})
    else $error("bad vector address");
  a_ack_time: assert property (take_s |-> vec_out.ack)
    else $error("late vector answer");
  a_ack_pulse: assert property (vec_out.ack |=> !vec_out.ack)
    else $error("long vector answer");
  a_nmi_level: assert property (vec_out.ack &&
    $past(vec_num, 3) == NMI_NUM |-> vec_out.level == NMI_LEVEL)
    else $error("bad nmi level");
  a_trap_flat: assert property (vec_out.ack &&
    $past(vec_num, 3) < NMI_NUM |-> !vec_out.has_level)
    else $error("trap has level");
  a_swi_flat: assert property (vec_out.ack &&
    $past(vec_num, 3) > PERIPH_LAST |-> !vec_out.has_level)
    else $error("upper number has level");
  a_irq_range: assert property (irq_valid |->
    irq_number inside {[NMI_NUM:PERIPH_LAST]})
    else $error("bad winner number");
  a_nmi_wake: assert property (nmi_req |=> wake_req && irq_valid)
    else $error("nmi missed");
  a_all_quiet: assert property (!nmi_req && src_req == '0 |=>
    !irq_valid && !wake_req)
    else $error("spurious request");
endmodule : ivm_vector_map_assertions

bind ivm_vector_map ivm_vector_map_assertions u_chk (.clk, .reset_n,
  .nmi_req, .src_req, .table_base_reg, .vec_req, .vec_num, .irq_valid,
  .irq_number, .wake_req, .vec_out);

// ### dv/ivm_cpu_model.sv
// Core side: asks for one vector and waits for the answer
module ivm_cpu_model
  import ivm_pkg::*;
(
  input wire logic clk,
  input ivm_pkg::ivm_vec_type vec_out,
  output logic vec_req,
  output logic [7:0] vec_num
);
  timeunit 1ns;
  timeprecision 1ns;
  initial vec_req = 1'b0;
  initial vec_num = 8'h00;
  // One-cycle request, number scrambled once released
  task automatic fetch(input logic [7:0] n, output ivm_vec_type v);
    int i;
    @(negedge clk);
    vec_req = 1'b1;
    vec_num = n;
    @(negedge clk);
    vec_req = 1'b0;
    vec_num = ~n;
    for (i = 0; i < 8 && vec_out.ack !== 1'b1; i++)
      @(negedge clk);
    v = vec_out;
  endtask : fetch
endmodule : ivm_cpu_model

// ### dv/ivm_vector_map_tb.sv
module ivm_vector_map_tb;
  import ivm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic nmi_req = 1'b0;
  ivm_src_type src_req = '0;
  ivm_levels_type level_reg;
  logic [31:0] table_base_reg = BASE_DEFAULT;
  logic vec_req;
  logic [7:0] vec_num;
  logic irq_valid;
  logic [4:0] irq_level;
  logic [7:0] irq_number;
  logic wake_req;
  ivm_vec_type vec_out;
  int mismatches = 0;
  int checks = 0;

  always #10 clk = ~clk;

  ivm_vector_map #(.N_PERIPH(48)) u_dut (.clk, .reset_n, .nmi_req, .src_req,
    .level_reg, .table_base_reg, .vec_req, .vec_num, .irq_valid, .irq_level,
    .irq_number, .wake_req, .vec_out);
  ivm_cpu_model u_cpu (.clk, .vec_out, .vec_req, .vec_num);

  // Compares and counts
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Vector lookups over every kind of table entry, two bases
  task automatic test_vectors;
    logic [7:0] n [7] = '{8'h01, 8'h0e, 8'h0f, 8'h10, 8'h3f, 8'h41, 8'hff};
    ivm_vec_type v;
    logic hl;
    foreach (n[i])
    begin
      table_base_reg = (i % 2 == 1) ? 32'h0010_0000 : BASE_DEFAULT;
      u_cpu.fetch(n[i], v);
      hl = n[i] == 8'h0f || (n[i] >= 8'h10 && n[i] <= 8'h3f);
      check(v.addr, table_base_reg + 32'h3fc - 4 * n[i]);
      check(v.has_level, hl);
      check(v.level, n[i] == 8'h0f ? 5'h0f :
        hl ? level_reg[n[i] - 8'h10] : 5'h1f);
    end
    $display("vector test done");
  endtask : test_vectors

  // Applies requests, winner shows one edge later
  task automatic arb(input logic m, input ivm_src_type s,
    input logic [14:0] exp);
    nmi_req = m;
    src_req = s;
    @(negedge clk);
    check({wake_req, irq_valid, irq_level, irq_number}, exp);
  endtask : arb

  // Level k+2 on slot k: 29 is disabled, 30 is strongest
  task automatic test_arbitration;
    arb(1'b0, '{ext:8'h08, dma:5'h01, default:'0}, 15'h6513);
    arb(1'b0, '{ext:8'h80, default:'0}, 15'h6917);
    arb(1'b1, '{misc:48'h2000, default:'0}, 15'h6f0f);
    arb(1'b0, '{dma:5'h10, default:'0}, 15'h7725);
    arb(1'b0, '{rt3:1'b1, default:'0}, 15'h602e);
    arb(1'b0, '{osc_wait:1'b1, default:'0}, 15'h602e);
    arb(1'b0, '{delay_bit:1'b1, default:'0}, 15'h713f);
    arb(1'b0, '{misc:48'h2000_0000, default:'0}, 15'h1f00);
    arb(1'b0, '0, 15'h1f00);
    $display("arbitration test done");
  endtask : test_arbitration

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // Watchdog
  initial
  begin
    #40000;
    mismatches++;
    finish_test;
  end

  // Main sequence
  initial
  begin
    for (int k = 0; k < NUM_PERIPH; k++)
      level_reg[k] = 5'(k + 2);
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    test_vectors;
    test_arbitration;
    finish_test;
  end
endmodule : ivm_vector_map_tb
